/* logic/lic_input_stage_cfg.v */
// AHB-Lite slave holding the receive input stage configuration register and its decode.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "lic_input_stage_consts.vh"

module lic_input_stage_cfg (
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    output wire per_channel_gain_select,
    output wire [1:0] global_amp_gain,
    output wire gain_valid,
    output wire amp_highpass_off,
    output wire [1:0] input_clamp_level,
    output wire clamp_auto,
    output wire termination_on,
    output wire [1:0] global_termination_code,
    output wire individual_resistor_select,
    output wire [4:0] individual_resistor_code,
    output reg [4:0] active_resistor_code,
    output reg [10:0] input_impedance_ohms
);

////////////////////////////////////////////////////////////////////////////////

reg [15:0] cfg_q;
reg wr_pend_q;
wire xfer;
wire addr_hit;
wire wr_commit;
wire [15:0] wdata_masked;
wire [15:0] cfg_next;
reg [4:0] eff_code;
wire wr_take;
wire rd_take;
wire size_word;
wire [31:0] rd_word;

// Decoded views of the stored fields.
reg gain_ok;
reg clamp_is_auto;

// The slave never inserts wait states of its own; a low clock enable stalls
// the bus instead, so no transfer is half taken while state is frozen.
assign hreadyout = clk_en;
assign hresp = `LIC_HRESP_OKAY;

assign xfer = hsel & htrans[1] & hready;
assign addr_hit = ({haddr[31:2], 2'b00} == `LIC_CFG_ADDR);
assign size_word = (hsize == `LIC_HSIZE_WORD);

// Narrow writes are dropped whole: a half-word store would leave the
// register half updated, which software has no way to see or undo.
assign wr_take = xfer & hwrite & addr_hit & size_word;
assign rd_take = xfer & ~hwrite;
assign wr_commit = wr_pend_q & clk_en;
assign wdata_masked = hwdata[15:0] & `LIC_CFG_WMASK;
assign cfg_next = wr_commit ? wdata_masked : cfg_q;

// Readback shows the value that stands after this edge, upper half zero.
assign rd_word = {16'h0000, cfg_next};

////////////////////////////////////////////////////////////////////////////////

// Address phase arms a write; the data phase commits it. A read in the
// cycle after a write sees the new value through cfg_next.
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        cfg_q <= `LIC_CFG_RESET;
        wr_pend_q <= 1'b0;
        hrdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
        cfg_q <= cfg_next;
        wr_pend_q <= wr_take;
        if (rd_take)
        begin
            if (addr_hit)
            begin
                hrdata <= rd_word;
            end
            else
            begin
                hrdata <= 32'h0000_0000;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

assign per_channel_gain_select = cfg_q[`LIC_GAIN_IND_BIT];
assign global_amp_gain = cfg_q[`LIC_GAIN_HI:`LIC_GAIN_LO];
assign gain_valid = gain_ok;
assign amp_highpass_off = cfg_q[`LIC_HPF_OFF_BIT];
assign input_clamp_level = cfg_q[`LIC_CLAMP_HI:`LIC_CLAMP_LO];
assign clamp_auto = clamp_is_auto;
assign termination_on = cfg_q[`LIC_TERM_ON_BIT];
assign global_termination_code = cfg_q[`LIC_GTERM_HI:`LIC_GTERM_LO];
assign individual_resistor_select = cfg_q[`LIC_IND_SEL_BIT];
assign individual_resistor_code = cfg_q[`LIC_IND_HI:`LIC_IND_LO];

// Only the three documented gain codes count. The reserved code is refused
// here so that nothing downstream picks a table column for it.
always @*
begin
    case (global_amp_gain)
        `LIC_GAIN_18DB: gain_ok = 1'b1;
        `LIC_GAIN_24DB: gain_ok = 1'b1;
        `LIC_GAIN_12DB: gain_ok = 1'b1;
        default: gain_ok = 1'b0;
    endcase
end

// The three fixed clamp codes are passed on as stored.
always @*
begin
    case (input_clamp_level)
        `LIC_CLAMP_AUTO: clamp_is_auto = 1'b1;
        default: clamp_is_auto = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////

// Resistor code that gives the nearest match to the global termination
// value at each gain, except that at 12 dB the first value leaves the input at high impedance.
// At 18 dB only the last value is exact, so the closest is used for the other three.
function [4:0] global_map;
    input [1:0] gain;
    input [1:0] gcode;
    begin
        case (gain)
            `LIC_GAIN_18DB:
            begin
                case (gcode)
                    2'b00: global_map = 5'h07;
                    2'b01: global_map = 5'h0e;
                    2'b10: global_map = 5'h1c;
                    default: global_map = 5'h18;
                endcase
            end
            `LIC_GAIN_24DB:
            begin
                case (gcode)
                    2'b00: global_map = 5'h01;
                    2'b01: global_map = 5'h02;
                    2'b10: global_map = 5'h04;
                    default: global_map = 5'h08;
                endcase
            end
            `LIC_GAIN_12DB:
            begin
                case (gcode)
                    2'b00: global_map = 5'h00;
                    2'b01: global_map = 5'h03;
                    2'b10: global_map = 5'h06;
                    default: global_map = 5'h0c;
                endcase
            end
            default: global_map = 5'h00;
        endcase
    end
endfunction

// Active termination resistance in ohms for a code at a gain; zero means
// high impedance. The passive 15 kohm in parallel is not folded in.
function [10:0] imp_lookup;
    input [1:0] gain;
    input [4:0] code;
    begin
        case ({gain, code})
            // 18 dB column. Code zero leaves the input at high impedance.
            7'h00: imp_lookup = 11'h000;
            7'h01: imp_lookup = 11'h05a;
            7'h02: imp_lookup = 11'h0b4;
            7'h03: imp_lookup = 11'h03c;
            7'h04: imp_lookup = 11'h168;
            7'h05: imp_lookup = 11'h048;
            7'h06: imp_lookup = 11'h078;
            7'h07: imp_lookup = 11'h033;
            7'h08: imp_lookup = 11'h2d0;
            7'h09: imp_lookup = 11'h050;
            7'h0a: imp_lookup = 11'h090;
            7'h0b: imp_lookup = 11'h037;
            7'h0c: imp_lookup = 11'h0f0;
            7'h0d: imp_lookup = 11'h041;
            7'h0e: imp_lookup = 11'h067;
            7'h0f: imp_lookup = 11'h030;
            7'h10: imp_lookup = 11'h384;
            7'h11: imp_lookup = 11'h052;
            7'h12: imp_lookup = 11'h096;
            7'h13: imp_lookup = 11'h038;
            7'h14: imp_lookup = 11'h101;
            7'h15: imp_lookup = 11'h043;
            7'h16: imp_lookup = 11'h06a;
            7'h17: imp_lookup = 11'h031;
            7'h18: imp_lookup = 11'h190;
            7'h19: imp_lookup = 11'h049;
            7'h1a: imp_lookup = 11'h07c;
            7'h1b: imp_lookup = 11'h034;
            7'h1c: imp_lookup = 11'h0bd;
            7'h1d: imp_lookup = 11'h03d;
            7'h1e: imp_lookup = 11'h05c;
            7'h1f: imp_lookup = 11'h02e;

            // 24 dB column.
            7'h20: imp_lookup = 11'h000;
            7'h21: imp_lookup = 11'h032;
            7'h22: imp_lookup = 11'h064;
            7'h23: imp_lookup = 11'h021;
            7'h24: imp_lookup = 11'h0c8;
            7'h25: imp_lookup = 11'h028;
            7'h26: imp_lookup = 11'h043;
            7'h27: imp_lookup = 11'h01d;
            7'h28: imp_lookup = 11'h190;
            7'h29: imp_lookup = 11'h02c;
            7'h2a: imp_lookup = 11'h050;
            7'h2b: imp_lookup = 11'h01f;
            7'h2c: imp_lookup = 11'h085;
            7'h2d: imp_lookup = 11'h024;
            7'h2e: imp_lookup = 11'h039;
            7'h2f: imp_lookup = 11'h01b;
            7'h30: imp_lookup = 11'h1f4;
            7'h31: imp_lookup = 11'h02d;
            7'h32: imp_lookup = 11'h053;
            7'h33: imp_lookup = 11'h01f;
            7'h34: imp_lookup = 11'h08f;
            7'h35: imp_lookup = 11'h025;
            7'h36: imp_lookup = 11'h03b;
            7'h37: imp_lookup = 11'h01b;
            7'h38: imp_lookup = 11'h0de;
            7'h39: imp_lookup = 11'h029;
            7'h3a: imp_lookup = 11'h045;
            7'h3b: imp_lookup = 11'h01d;
            7'h3c: imp_lookup = 11'h069;
            7'h3d: imp_lookup = 11'h022;
            7'h3e: imp_lookup = 11'h033;
            7'h3f: imp_lookup = 11'h019;

            // 12 dB column.
            7'h40: imp_lookup = 11'h000;
            7'h41: imp_lookup = 11'h096;
            7'h42: imp_lookup = 11'h12c;
            7'h43: imp_lookup = 11'h064;
            7'h44: imp_lookup = 11'h258;
            7'h45: imp_lookup = 11'h078;
            7'h46: imp_lookup = 11'h0c8;
            7'h47: imp_lookup = 11'h056;
            7'h48: imp_lookup = 11'h4b0;
            7'h49: imp_lookup = 11'h085;
            7'h4a: imp_lookup = 11'h0f0;
            7'h4b: imp_lookup = 11'h05c;
            7'h4c: imp_lookup = 11'h190;
            7'h4d: imp_lookup = 11'h06d;
            7'h4e: imp_lookup = 11'h0ab;
            7'h4f: imp_lookup = 11'h050;
            7'h50: imp_lookup = 11'h5dc;
            7'h51: imp_lookup = 11'h088;
            7'h52: imp_lookup = 11'h0fa;
            7'h53: imp_lookup = 11'h05e;
            7'h54: imp_lookup = 11'h1ad;
            7'h55: imp_lookup = 11'h06f;
            7'h56: imp_lookup = 11'h0b0;
            7'h57: imp_lookup = 11'h051;
            7'h58: imp_lookup = 11'h29b;
            7'h59: imp_lookup = 11'h07a;
            7'h5a: imp_lookup = 11'h0cf;
            7'h5b: imp_lookup = 11'h057;
            7'h5c: imp_lookup = 11'h13c;
            7'h5d: imp_lookup = 11'h066;
            7'h5e: imp_lookup = 11'h09a;
            7'h5f: imp_lookup = 11'h04c;
            // The reserved gain has no column and reads as high impedance.
            default: imp_lookup = 11'h000;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

// A reserved gain has no valid table column, so termination is parked at
// high impedance rather than guessing a resistor setting.
always @*
begin
    eff_code = 5'h00;
    if (termination_on & gain_valid)
    begin
        if (individual_resistor_select)
        begin
            eff_code = individual_resistor_code;
        end
        else
        begin
            eff_code = global_map(global_amp_gain, global_termination_code);
        end
    end
end

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        active_resistor_code <= 5'h00;
        input_impedance_ohms <= 11'h000;
    end
    else if (clk_en)
    begin
        active_resistor_code <= eff_code;
        input_impedance_ohms <= imp_lookup(global_amp_gain, eff_code);
    end
end

endmodule
`default_nettype wire

/* logic/lic_input_stage_consts.vh */
// Constants for the input stage configuration register block.
`ifndef LIC_INPUT_STAGE_CONSTS_VH
`define LIC_INPUT_STAGE_CONSTS_VH

// Register index of the configuration word. Each index is one 32-bit word,
// so the byte address on the AHB-Lite bus is four times the index.
`define LIC_CFG_INDEX 8'hc4
`define LIC_CFG_ADDR 32'h0000_0310
`define LIC_CFG_RESET 16'h0000
// Bit 11 is reserved: never stored, always reads zero.
`define LIC_CFG_WMASK 16'hf7ff

// Field positions.
`define LIC_GAIN_IND_BIT 15
`define LIC_GAIN_HI 14
`define LIC_GAIN_LO 13
`define LIC_HPF_OFF_BIT 12
`define LIC_CLAMP_HI 10
`define LIC_CLAMP_LO 9
`define LIC_TERM_ON_BIT 8
`define LIC_GTERM_HI 7
`define LIC_GTERM_LO 6
`define LIC_IND_SEL_BIT 5
`define LIC_IND_HI 4
`define LIC_IND_LO 0

// Global gain encodings.
`define LIC_GAIN_18DB 2'b00
`define LIC_GAIN_24DB 2'b01
`define LIC_GAIN_12DB 2'b10
`define LIC_GAIN_RSVD 2'b11

// Automatic clamp level code.
`define LIC_CLAMP_AUTO 2'b00

// AHB encodings used by the slave.
`define LIC_HSIZE_WORD 3'b010
`define LIC_HRESP_OKAY 1'b0

`endif

/* sim/lic_input_stage_cfg_asserts.sv */
// Concurrent checks on the ports of the input stage configuration block.
`timescale 1ns/1ns
`default_nettype none
module lic_cfg_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic per_channel_gain_select,
    input wire logic [1:0] global_amp_gain,
    input wire logic gain_valid,
    input wire logic amp_highpass_off,
    input wire logic [1:0] input_clamp_level,
    input wire logic clamp_auto,
    input wire logic termination_on,
    input wire logic [1:0] global_termination_code,
    input wire logic individual_resistor_select,
    input wire logic [4:0] individual_resistor_code,
    input wire logic [4:0] active_resistor_code,
    input wire logic [10:0] input_impedance_ohms
);
    logic take;
    logic wr_q;
    assign take = hsel && htrans[1] && hready && clk_en;
    // A stalled data phase keeps the pending write armed.
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            wr_q <= 1'b0;
        else if (clk_en)
            wr_q <= take && hwrite && haddr[31:2] == 30'h0c4 && hsize == 3'h2;
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_wr_hi;
        wr_q && clk_en |=> {per_channel_gain_select, global_amp_gain, amp_highpass_off}
            == $past(hwdata[15:12]);
    endproperty
    a_wr_hi: assert property (p_wr_hi) else $error("upper fields wrong");
    property p_wr_lo;
        wr_q && clk_en |=> {input_clamp_level, termination_on, global_termination_code,
            individual_resistor_select, individual_resistor_code} == $past(hwdata[10:0]);
    endproperty
    a_wr_lo: assert property (p_wr_lo) else $error("lower fields wrong");
    property p_gv;
        gain_valid == (global_amp_gain != 2'h3);
    endproperty
    a_gv: assert property (p_gv) else $error("gain valid wrong");
    property p_ca;
        clamp_auto == (input_clamp_level == 2'h0);
    endproperty
    a_ca: assert property (p_ca) else $error("clamp auto wrong");
    property p_off;
        clk_en && !termination_on |=> active_resistor_code == 5'h00 && input_impedance_ohms == 11'h0;
    endproperty
    a_off: assert property (p_off) else $error("termination not off");
    property p_ind;
        clk_en && termination_on && gain_valid && individual_resistor_select
            |=> active_resistor_code == $past(individual_resistor_code);
    endproperty
    a_ind: assert property (p_ind) else $error("individual code unused");
    property p_map;
        clk_en && termination_on && !individual_resistor_select && global_amp_gain == 2'h1
            |=> active_resistor_code == 5'h01 << $past(global_termination_code);
    endproperty
    a_map: assert property (p_map) else $error("global map wrong");
    property p_hiz;
        clk_en && termination_on && !individual_resistor_select && global_amp_gain == 2'h2
            && global_termination_code == 2'h0 |=> input_impedance_ohms == 11'h0;
    endproperty
    a_hiz: assert property (p_hiz) else $error("no high impedance");
    property p_rd;
        take && !hwrite |=> hrdata[31:16] == 16'h0 && !hrdata[11];
    endproperty
    a_rd: assert property (p_rd) else $error("read upper bits set");
    property p_resp;
        hresp == 1'b0;
    endproperty
    a_resp: assert property (p_resp) else $error("response not okay");
    property p_frz;
        !clk_en |=> $stable(active_resistor_code) && $stable(input_impedance_ohms)
            && $stable(hrdata) && $stable({per_channel_gain_select, global_amp_gain,
            amp_highpass_off, input_clamp_level, termination_on, global_termination_code,
            individual_resistor_select, individual_resistor_code});
    endproperty
    a_frz: assert property (p_frz) else $error("state moved while clock enable low");
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the input stage configuration register.
`timescale 1ns/1ns
`default_nettype none
`include "lic_input_stage_consts.vh"
module testbench;
    logic hclk, hresetn, hsel, hwrite, clk_en;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, q;
    wire hready, per_channel_gain_select, gain_valid, amp_highpass_off, clamp_auto;
    wire termination_on, individual_resistor_select;
    wire [1:0] global_amp_gain, input_clamp_level, global_termination_code;
    wire [4:0] individual_resistor_code, active_resistor_code;
    wire [10:0] input_impedance_ohms;
    wire [31:0] hrdata;
    int miscompares = 0;
    int n_tests = 0;
    logic [4:0] ec [0:2][0:3] = '{'{5'h07, 5'h0e, 5'h1c, 5'h18},
        '{5'h01, 5'h02, 5'h04, 5'h08}, '{5'h00, 5'h03, 5'h06, 5'h0c}};
    logic [10:0] eo [0:2][0:3] = '{'{11'h033, 11'h067, 11'h0bd, 11'h190},
        '{11'h032, 11'h064, 11'h0c8, 11'h190}, '{11'h000, 11'h064, 11'h0c8, 11'h190}};
    logic [15:0] iw [0:4] = '{16'h213f, 16'h2126, 16'h4130, 16'h203f, 16'h015f};
    logic [4:0] ic [0:4] = '{5'h1f, 5'h06, 5'h10, 5'h00, 5'h0e};
    logic [10:0] io [0:4] = '{11'h019, 11'h043, 11'h5dc, 11'h000, 11'h067};
    lic_input_stage_cfg i_lic_input_stage_cfg (.hclk, .hresetn, .clk_en, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready), .hresp(), .hrdata,
        .per_channel_gain_select, .global_amp_gain, .gain_valid, .amp_highpass_off,
        .input_clamp_level, .clamp_auto, .termination_on, .global_termination_code,
        .individual_resistor_select, .individual_resistor_code, .active_resistor_code,
        .input_impedance_ohms);
    ////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wait_rdy;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask
    // Derived outputs lag the register by one more edge.
    task settle;
        repeat (2) @(posedge hclk);
        #1;
    endtask
    task complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial
    begin
        #200000;
        miscompares++;
        complete_run;
    end
    initial
    begin
        hresetn = 1'b0;
        clk_en = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, `LIC_CFG_ADDR, 32'h0);
        chk("reset", q, 32'h0);
        ahb(1'b1, `LIC_CFG_ADDR, 32'hffff_ffff);
        ahb(1'b0, `LIC_CFG_ADDR, 32'h0);
        chk("masked", q, 32'h0000_f7ff);
        chk("gain_clamp", {global_amp_gain, input_clamp_level}, 32'hf);
        chk("term", {termination_on, global_termination_code}, 32'h7);
        chk("ind", {individual_resistor_select, individual_resistor_code}, 32'h3f);
        chk("sel_hpf", {per_channel_gain_select, amp_highpass_off}, 32'h3);
        chk("gain_valid", gain_valid, 32'h0);
        chk("resv_code", active_resistor_code, 32'h0);
        ahb(1'b1, 32'h0000_00c8, 32'h0);
        ahb(1'b0, 32'h0000_00c8, 32'h0);
        chk("unmapped", q, 32'h0);
        ahb(1'b0, `LIC_CFG_ADDR, 32'h0);
        chk("kept", q, 32'h0000_f7ff);
        for (int g = 0; g < 3; g++)
            for (int j = 0; j < 4; j++)
            begin
                ahb(1'b1, `LIC_CFG_ADDR, {16'h0, 1'b0, g[1:0], 2'b00, j[1:0], 1'b1, j[1:0], 6'h00});
                settle;
                chk("clamp_auto", clamp_auto, j == 0);
                chk("gbl_code", active_resistor_code, ec[g][j]);
                chk("gbl_ohms", input_impedance_ohms, eo[g][j]);
            end
        for (int k = 0; k < 5; k++)
        begin
            ahb(1'b1, `LIC_CFG_ADDR, {16'h0, iw[k]});
            settle;
            chk("ind_code", active_resistor_code, ic[k]);
            chk("ind_ohms", input_impedance_ohms, io[k]);
        end
        // A low clock enable stalls the bus and freezes every register.
        @(posedge hclk);
        clk_en <= 1'b0;
        fork
            ahb(1'b1, `LIC_CFG_ADDR, 32'h0);
            begin
                repeat (3) @(posedge hclk);
                #1;
                chk("stall_rdy", hready, 32'h0);
                chk("stall_code", active_resistor_code, 32'h0e);
                chk("stall_gtc", global_termination_code, 32'h1);
                @(posedge hclk);
                clk_en <= 1'b1;
            end
        join
        settle;
        chk("unstalled", active_resistor_code, 32'h0);
        complete_run;
    end
endmodule
bind lic_input_stage_cfg lic_cfg_chk i_lic_cfg_chk (.hclk, .hresetn, .clk_en, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hresp, .hrdata, .per_channel_gain_select,
    .global_amp_gain, .gain_valid, .amp_highpass_off, .input_clamp_level, .clamp_auto,
    .termination_on, .global_termination_code, .individual_resistor_select,
    .individual_resistor_code, .active_resistor_code, .input_impedance_ohms);
`default_nettype wire
